// ---- hdl/core_addr_pkg.sv ----
/*
  Package for the core addressing and branching block: memory map
  boundaries, register offsets, reset values, cycle counts and opcodes.
  Assumes a single 10 MHz system clock and an 8051-class data path.
*/
package core_addr_pkg;
  // Data memory map.
  localparam logic [7:0] BANK_TOP = 8'h1F;
  localparam logic [7:0] BIT_BYTE_BASE = 8'h20;
  localparam logic [7:0] LOWER_TOP = 8'h7F;
  localparam logic [7:0] SP_ADDR = 8'h81;
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam int BANK_LO_POS = 3;
  localparam int BANK_HI_POS = 4;
  localparam logic [2:0] SFR_BITABLE_MASK = 3'h7;
  // Program memory map.
  localparam logic [15:0] RESERVED_BASE = 16'hFC00;
  // Stack record.
  localparam int REC_WIDTH = 32;
  localparam logic [5:0] REC_DEPTH = 6'h20;
  // Cycle counts.
  localparam logic [2:0] CYC_NOP = 3'h1;
  localparam logic [2:0] CYC_SHORT_NT = 3'h2;
  localparam logic [2:0] CYC_SHORT_T = 3'h3;
  localparam logic [2:0] CYC_LONG_NT = 3'h3;
  localparam logic [2:0] CYC_LONG_T = 3'h4;
  localparam logic [2:0] CYC_SJMP = 3'h3;
  localparam logic [2:0] CYC_PAGE = 3'h3;
  localparam logic [2:0] CYC_FULL = 3'h4;
  localparam logic [2:0] CYC_RET = 3'h5;
  localparam logic [2:0] CYC_OTHER = 3'h1;
  // Opcodes handled by the branch sequencer.
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_SPARE = 8'hA5;
  localparam logic [7:0] OP_JC = 8'h40;
  localparam logic [7:0] OP_JNC = 8'h50;
  localparam logic [7:0] OP_JZ = 8'h60;
  localparam logic [7:0] OP_JNZ = 8'h70;
  localparam logic [7:0] OP_SJMP = 8'h80;
  localparam logic [7:0] OP_JBC = 8'h10;
  localparam logic [7:0] OP_JB = 8'h20;
  localparam logic [7:0] OP_JNB = 8'h30;
  localparam logic [7:0] OP_LJMP = 8'h02;
  localparam logic [7:0] OP_LCALL = 8'h12;
  localparam logic [7:0] OP_RET = 8'h22;
  localparam logic [7:0] OP_DECREMENT_JUMP_NONZERO_D = 8'hD5;
  localparam logic [3:0] OP_DECREMENT_JUMP_NONZERO_R_HI = 4'hD;
  localparam logic [3:0] OP_COMPARE_JUMP_UNEQUAL_HI = 4'hB;
  localparam logic [4:0] OP_AJMP_LO = 5'h01;
  localparam logic [4:0] OP_ACALL_LO = 5'h11;
  // Stack pointer operation codes from the execution unit.
  typedef enum logic [2:0] {
    SPOP_NONE, SPOP_PUSH, SPOP_POP, SPOP_CALL, SPOP_RET, SPOP_INC, SPOP_DEC
  } sp_op_t;
endpackage

// ---- hdl/stack_record.sv ----
/*
  Debug stack-record shift register with overflow and underflow detection.
  Assumes one stack operation per clock, presented as a one-cycle code.
*/
`timescale 1ns/1ns
module stack_record (
  input wire logic sys_clk_i, // System clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire core_addr_pkg::sp_op_t op_i, // Stack operation this cycle.
  input wire logic [1:0] rec_bits_i, // Record bits to shift in.
  output logic [31:0] rec_o, // Shift register contents.
  output logic [5:0] fill_o, // Number of valid record bits.
  output logic overflow_o, // Sticky overflow flag.
  output logic underflow_o // Sticky underflow flag.
);
  import core_addr_pkg::*;
  logic [5:0] n_in, n_out;

  // Bits moved per operation: one for push or pop, two for call or return.
  always_comb begin
    n_in = 6'h0;
    n_out = 6'h0;
    case (op_i)
      SPOP_PUSH, SPOP_INC: n_in = 6'h1;
      SPOP_CALL: n_in = 6'h2;
      SPOP_POP, SPOP_DEC: n_out = 6'h1;
      SPOP_RET: n_out = 6'h2;
      default: ;
    endcase
  end

  // Shift the record; the fill count saturates so a flag marks the loss.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rec_o <= 32'h0; // see [RL23]
      fill_o <= 6'h0;
      overflow_o <= 1'b0;
      underflow_o <= 1'b0;
    end else if (n_in == 6'h1) begin
      rec_o <= {rec_o[30:0], rec_bits_i[0]}; // see [RL19]
      if (fill_o == REC_DEPTH) overflow_o <= 1'b1; // see [RL20]
      else fill_o <= fill_o + 6'h1;
    end else if (n_in == 6'h2) begin
      rec_o <= {rec_o[29:0], rec_bits_i}; // see [RL19]
      if (fill_o > REC_DEPTH - 6'h2) begin
        overflow_o <= 1'b1; // see [RL20]
        fill_o <= REC_DEPTH;
      end else fill_o <= fill_o + 6'h2;
    end else if (n_out != 6'h0) begin
      rec_o <= rec_o >> n_out; // see [RL19]
      if (fill_o < n_out) begin
        underflow_o <= 1'b1; // see [RL20]
        fill_o <= 6'h0;
      end else fill_o <= fill_o - n_out;
    end
  end
endmodule // stack_record

// ---- hdl/core_addr.sv ----
/*
  Branch sequencer and data address decoder of an 8051-class core.
  Assumes the fetch unit presents a whole instruction with its operand
  bytes and condition inputs, and takes the next PC when done_o pulses.
*/
`timescale 1ns/1ns
// Notes on behaviour
// [RL1] Short conditional jumps: 2 cycles, taken 3.
// [RL2] Bit jumps 3/4; clear variant clears set bit.
// [RL3] Short unconditional relative jump: 3 cycles.
// [RL4] Compare jump unequal: 3 equal, 4 taken.
// [RL5] Direct decrement jump: 3 or 4 cycles.
// [RL6] Relative target from next instruction address.
// [RL7] Page target keeps upper five address bits.
// [RL8] Long target is full 16-bit address.
// [RL9] Spare opcode behaves as no-operation.
// [RL10] Software avoids top reserved kilobyte of code.
// [RL11] Code writes only while flash writes enabled.
// [RL12] Status bits three, four choose register bank.
// [RL13] Indirect pointers are first two bank registers.
// [RL14] Bit addresses map into bytes 0x20-0x2F.
// [RL15] Direct above 0x7F selects function registers.
// [RL16] Indirect above 0x7F selects upper RAM.
// [RL17] Stack pointer increments before each push.
// [RL18] Reset loads stack pointer with 0x07.
// [RL19] Record shifts one per push, two per call.
// [RL20] Record flags overflow and underflow at speed.
// [RL21] Only function registers at x0/x8 are bitwise.
// [RL22] Software avoids unoccupied function register addresses.
// [RL23] Record and flags clear on reset.
module core_addr (
  input wire logic sys_clk_i, // System clock, 10 MHz.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic start_i, // Pulse: new instruction presented.
  input wire logic [7:0] opcode_i, // Instruction opcode.
  input wire logic [7:0] op1_i, // First operand byte.
  input wire logic [7:0] op2_i, // Second operand byte.
  input wire logic [15:0] pc_i, // Address of the instruction.
  input wire logic [15:0] ret_addr_i, // Popped return address.
  input wire logic carry_i, // Carry flag.
  input wire logic acc_zero_i, // Accumulator is zero.
  input wire logic bit_val_i, // Value of the tested bit.
  input wire logic cmp_equal_i, // Compare operands are equal.
  input wire logic [7:0] dec_src_i, // Byte before decrement.
  output logic busy_o, // Instruction in progress.
  output logic done_o, // Pulse: instruction retires.
  output logic [15:0] next_pc_o, // Next program counter.
  output logic branch_taken_o, // Last branch was taken.
  output logic clear_bit_o, // Pulse with done: clear tested bit.
  output logic [2:0] cycles_o, // Cycle count of last instruction.
  input wire logic [7:0] program_status_word_i, // Status word.
  input wire logic [2:0] reg_sel_i, // Register number in bank.
  input wire logic ind_sel_i, // Pointer register for indirect.
  input wire logic [7:0] ind_ptr_i, // Content of the pointer register.
  input wire logic [7:0] direct_addr_i, // Direct operand address.
  input wire logic [7:0] bit_addr_i, // Bit operand address.
  output logic [7:0] reg_addr_o, // RAM address of bank register.
  output logic [7:0] ind_reg_addr_o, // RAM address of pointer reg.
  output logic ind_upper_o, // Indirect hits upper RAM.
  output logic direct_sfr_o, // Direct hits function registers.
  output logic [7:0] bit_byte_o, // Byte holding the bit.
  output logic [2:0] bit_pos_o, // Bit position in the byte.
  output logic bit_in_sfr_o, // Bit lies in a function register.
  output logic sfr_bitable_o, // Direct address is bit accessible.
  input wire logic code_read_i, // Code read move request.
  input wire logic ext_write_i, // External data write request.
  input wire logic flash_write_en_i, // Flash writes enabled.
  output logic code_rd_o, // Read strobe to program flash.
  output logic code_wr_o, // Write strobe to program flash.
  output logic xdata_wr_o, // Write strobe to external data.
  input wire logic sfr_wr_i, // Function register write strobe.
  input wire logic sfr_rd_i, // Function register read strobe.
  input wire logic [7:0] sfr_addr_i, // Function register address.
  input wire logic [7:0] sfr_wdata_i, // Function register write data.
  output logic [7:0] sfr_rdata_o, // Function register read data.
  output logic sfr_hit_o, // Read address is ours.
  input wire core_addr_pkg::sp_op_t sp_op_i, // Stack op this cycle.
  output logic [7:0] push_addr_o, // Address of the next push write.
  output logic [7:0] stack_top_pointer_o, // Stack pointer value.
  output logic [31:0] rec_o, // Stack record contents.
  output logic rec_overflow_o, // Stack record overflowed.
  output logic rec_underflow_o // Stack record underflowed.
);
  import core_addr_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT} seq_state_t;
  seq_state_t state_r;
  logic [2:0] cnt_r, cyc_nxt;
  logic [15:0] pc_nxt, seq_pc;
  logic taken_nxt, clr_nxt;
  logic [7:0] stack_top_pointer_r;
  logic [1:0] bank;

  // Relative target: signed offset added to the next instruction address.
  function automatic logic [15:0] rel_target(input logic [15:0] nxt,
                                             input logic [7:0] off);
    rel_target = nxt + {{8{off[7]}}, off}; // see [RL6]
  endfunction

  // Length in bytes of the instructions handled here.
  function automatic logic [1:0] op_len(input logic [7:0] op);
    if (op == OP_LJMP || op == OP_LCALL || op == OP_JB || op == OP_JNB ||
        op == OP_JBC || op == OP_DECREMENT_JUMP_NONZERO_D || op[7:4] == OP_COMPARE_JUMP_UNEQUAL_HI)
      op_len = 2'h3;
    else if (op == OP_JC || op == OP_JNC || op == OP_JZ || op == OP_JNZ ||
             op == OP_SJMP || op[4:0] == OP_AJMP_LO ||
             op[4:0] == OP_ACALL_LO || op[7:3] == {OP_DECREMENT_JUMP_NONZERO_R_HI, 1'b1})
      op_len = 2'h2;
    else
      op_len = 2'h1;
  endfunction

  // Decode: choose the target and the cycle count for this instruction.
  always_comb begin
    seq_pc = pc_i + {14'h0, op_len(opcode_i)};
    pc_nxt = seq_pc;
    taken_nxt = 1'b0;
    clr_nxt = 1'b0;
    cyc_nxt = CYC_OTHER;
    if (opcode_i == OP_NOP || opcode_i == OP_SPARE) begin
      cyc_nxt = CYC_NOP; // see [RL9]
    end else if (opcode_i == OP_JC || opcode_i == OP_JNC ||
                 opcode_i == OP_JZ || opcode_i == OP_JNZ ||
                 opcode_i[7:3] == {OP_DECREMENT_JUMP_NONZERO_R_HI, 1'b1}) begin
      case (opcode_i)
        OP_JC: taken_nxt = carry_i;
        OP_JNC: taken_nxt = !carry_i;
        OP_JZ: taken_nxt = acc_zero_i;
        OP_JNZ: taken_nxt = !acc_zero_i;
        default: taken_nxt = dec_src_i != 8'h01;
      endcase
      cyc_nxt = taken_nxt ? CYC_SHORT_T : CYC_SHORT_NT; // see [RL1]
      if (taken_nxt) pc_nxt = rel_target(seq_pc, op1_i);
    end else if (opcode_i == OP_JB || opcode_i == OP_JNB ||
                 opcode_i == OP_JBC) begin
      taken_nxt = (opcode_i == OP_JNB) ? !bit_val_i : bit_val_i;
      clr_nxt = (opcode_i == OP_JBC) && bit_val_i; // see [RL2]
      cyc_nxt = taken_nxt ? CYC_LONG_T : CYC_LONG_NT; // see [RL2]
      if (taken_nxt) pc_nxt = rel_target(seq_pc, op2_i);
    end else if (opcode_i[7:4] == OP_COMPARE_JUMP_UNEQUAL_HI && opcode_i[3:0] >= 4'h4) begin
      taken_nxt = !cmp_equal_i;
      cyc_nxt = taken_nxt ? CYC_LONG_T : CYC_LONG_NT; // see [RL4]
      if (taken_nxt) pc_nxt = rel_target(seq_pc, op2_i);
    end else if (opcode_i == OP_DECREMENT_JUMP_NONZERO_D) begin
      taken_nxt = dec_src_i != 8'h01;
      cyc_nxt = taken_nxt ? CYC_LONG_T : CYC_LONG_NT; // see [RL5]
      if (taken_nxt) pc_nxt = rel_target(seq_pc, op2_i);
    end else if (opcode_i == OP_SJMP) begin
      taken_nxt = 1'b1;
      cyc_nxt = CYC_SJMP; // see [RL3]
      pc_nxt = rel_target(seq_pc, op1_i);
    end else if (opcode_i[4:0] == OP_AJMP_LO ||
                 opcode_i[4:0] == OP_ACALL_LO) begin
      taken_nxt = 1'b1;
      cyc_nxt = CYC_PAGE;
      pc_nxt = {seq_pc[15:11], opcode_i[7:5], op1_i}; // see [RL7]
    end else if (opcode_i == OP_LJMP || opcode_i == OP_LCALL) begin
      taken_nxt = 1'b1;
      cyc_nxt = CYC_FULL;
      pc_nxt = {op1_i, op2_i}; // see [RL8]
    end else if (opcode_i == OP_RET) begin
      taken_nxt = 1'b1;
      cyc_nxt = CYC_RET;
      pc_nxt = ret_addr_i;
    end
  end

  // Sequencer: hold the instruction for its full cycle count.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      cnt_r <= 3'h0;
      done_o <= 1'b0;
      clear_bit_o <= 1'b0;
      next_pc_o <= 16'h0;
      branch_taken_o <= 1'b0;
      cycles_o <= 3'h0;
    end else begin
      done_o <= 1'b0;
      clear_bit_o <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (start_i) begin
            next_pc_o <= pc_nxt;
            branch_taken_o <= taken_nxt;
            cycles_o <= cyc_nxt;
            if (cyc_nxt == 3'h1) begin
              done_o <= 1'b1;
              clear_bit_o <= clr_nxt;
            end else begin
              cnt_r <= cyc_nxt - 3'h1;
              state_r <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          cnt_r <= cnt_r - 3'h1;
          if (cnt_r == 3'h1) begin
            done_o <= 1'b1;
            clear_bit_o <= (opcode_i == OP_JBC) && branch_taken_o;
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
  assign busy_o = (state_r == ST_WAIT);

  // Register bank and data address decoding, purely combinational.
  assign bank = {program_status_word_i[BANK_HI_POS],
                 program_status_word_i[BANK_LO_POS]}; // see [RL12]
  assign reg_addr_o = {3'h0, bank, reg_sel_i}; // see [RL12]
  assign ind_reg_addr_o = {3'h0, bank, 2'h0, ind_sel_i}; // see [RL13]
  assign ind_upper_o = ind_ptr_i > LOWER_TOP; // see [RL16]
  assign direct_sfr_o = direct_addr_i > LOWER_TOP; // see [RL15]
  assign bit_in_sfr_o = bit_addr_i[7];
  assign bit_pos_o = bit_addr_i[2:0];
  // Low bit addresses fold into the bit byte area, high ones into x0/x8.
  assign bit_byte_o = bit_addr_i[7] ? {bit_addr_i[7:3], 3'h0} // see [RL21]
                    : BIT_BYTE_BASE + {4'h0, bit_addr_i[6:3]}; // see [RL14]
  assign sfr_bitable_o = direct_addr_i[7] && // see [RL21]
                         ((direct_addr_i[2:0] & SFR_BITABLE_MASK) == 3'h0);

  // Code reads always pass; code writes need the flash write enable.
  assign code_rd_o = code_read_i;
  assign code_wr_o = ext_write_i && flash_write_en_i; // see [RL11]
  assign xdata_wr_o = ext_write_i && !flash_write_en_i; // see [RL11]

  // Stack pointer: writes by software, updates by stack operations.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) stack_top_pointer_r <= SP_RESET; // see [RL18]
    else if (sfr_wr_i && sfr_addr_i == SP_ADDR)
      stack_top_pointer_r <= sfr_wdata_i;
    else case (sp_op_i)
      SPOP_PUSH, SPOP_INC: stack_top_pointer_r <= stack_top_pointer_r + 8'h1;
      SPOP_CALL: stack_top_pointer_r <= stack_top_pointer_r + 8'h2;
      SPOP_POP, SPOP_DEC: stack_top_pointer_r <= stack_top_pointer_r - 8'h1;
      SPOP_RET: stack_top_pointer_r <= stack_top_pointer_r - 8'h2;
      default: ;
    endcase
  end
  assign push_addr_o = stack_top_pointer_r + 8'h1; // see [RL17]
  assign stack_top_pointer_o = stack_top_pointer_r;

  // Read port for the stack pointer; other addresses read zero.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) sfr_rdata_o <= 8'h0;
    else if (sfr_rd_i)
      sfr_rdata_o <= (sfr_addr_i == SP_ADDR) ? stack_top_pointer_r : 8'h0;
  end
  assign sfr_hit_o = sfr_addr_i == SP_ADDR;

  // Record bits: the low pointer bit, and on a call a one above it.
  stack_record u_rec (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .op_i(sp_op_i),
    .rec_bits_i({1'b1, stack_top_pointer_r[0]}),
    .rec_o(rec_o),
    .fill_o(),
    .overflow_o(rec_overflow_o),
    .underflow_o(rec_underflow_o)
  );
endmodule // core_addr

// ---- tb/core_addr_sva.sv ----
/* Checker for the core addressing block: stack pointer, decode and
   branch timing. Assumes it is bound to every core_addr instance. */
`timescale 1ns/1ns
module core_addr_sva (
  input wire logic sys_clk_i, // Clock.
  input wire logic rst_i, // Reset.
  input wire logic start_i, // Start.
  input wire logic busy_o, // Busy.
  input wire logic done_o, // Retire pulse.
  input wire logic [7:0] opcode_i, // Opcode.
  input wire core_addr_pkg::sp_op_t sp_op_i, // Stack op.
  input wire logic sfr_wr_i, // Register write.
  input wire logic [7:0] stack_top_pointer_o, // Stack pointer.
  input wire logic [7:0] push_addr_o, // Push address.
  input wire logic [31:0] rec_o, // Record.
  input wire logic rec_overflow_o, // Overflow flag.
  input wire logic [7:0] program_status_word_i, // Status word.
  input wire logic [2:0] reg_sel_i, // Register number.
  input wire logic [7:0] reg_addr_o, // Register address.
  input wire logic [7:0] ind_ptr_i, // Pointer value.
  input wire logic ind_upper_o, // Upper RAM hit.
  input wire logic [7:0] direct_addr_i, // Direct address.
  input wire logic direct_sfr_o, // Register space hit.
  input wire logic ext_write_i, // External write.
  input wire logic flash_write_en_i, // Flash enable.
  input wire logic code_wr_o // Flash write.
);
  import core_addr_pkg::*;
  // One clock for all; reset silences every check except the reset one.
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence sjmp_start;
    start_i && !busy_o && opcode_i == OP_SJMP;
  endsequence
  sequence done_third;
    !done_o [*2] ##1 done_o;
  endsequence
  sp_reset_a: assert property (disable iff (1'b0) rst_i |=>
    stack_top_pointer_o == SP_RESET && rec_o == 0 && !rec_overflow_o)
    else $error("stack state not cleared by reset");
  push_incr_a: assert property (sp_op_i == SPOP_PUSH && !sfr_wr_i |=>
    stack_top_pointer_o == $past(stack_top_pointer_o) + 8'h01)
    else $error("push did not raise the stack pointer by one");
  push_addr_a: assert property (push_addr_o == stack_top_pointer_o + 8'h01)
    else $error("push address is not pointer plus one");
  bank_sel_a: assert property (reg_addr_o ==
    {3'h0, program_status_word_i[4:3], reg_sel_i})
    else $error("bank register address wrong");
  ind_upper_a: assert property (ind_upper_o == ind_ptr_i[7])
    else $error("indirect upper select wrong");
  direct_sfr_a: assert property (direct_sfr_o == direct_addr_i[7])
    else $error("direct register select wrong");
  sjmp_time_a: assert property (sjmp_start |=> done_third)
    else $error("short jump not retired in three cycles");
  code_gate_a: assert property (code_wr_o ==
    (ext_write_i && flash_write_en_i))
    else $error("flash write strobe not gated by enable");
endmodule // core_addr_sva
bind core_addr core_addr_sva chk (.sys_clk_i, .rst_i, .start_i, .busy_o,
  .done_o, .opcode_i, .sp_op_i, .sfr_wr_i, .stack_top_pointer_o,
  .push_addr_o, .rec_o, .rec_overflow_o, .program_status_word_i,
  .reg_sel_i, .reg_addr_o, .ind_ptr_i, .ind_upper_o, .direct_addr_i,
  .direct_sfr_o, .ext_write_i, .flash_write_en_i, .code_wr_o);

// ---- tb/flash_ram_model.sv ----
/* Far-side model of program flash and external data memory; it counts
   accesses. Assumes one access per clock while a strobe is high. */
`timescale 1ns/1ns
module flash_ram_model (
  input wire logic sys_clk_i, // Clock.
  input wire logic code_rd_i, // Flash read strobe.
  input wire logic code_wr_i, // Flash write strobe.
  input wire logic xdata_wr_i, // Data write strobe.
  output int rd_cnt_o = 0, // Flash reads seen.
  output int wr_cnt_o = 0, // Flash writes seen.
  output int xw_cnt_o = 0 // Data writes seen.
);
  // Flash trusts the core to gate writes, so every strobe is taken.
  always @(posedge sys_clk_i) begin
    rd_cnt_o <= rd_cnt_o + int'(code_rd_i);
    wr_cnt_o <= wr_cnt_o + int'(code_wr_i);
    xw_cnt_o <= xw_cnt_o + int'(xdata_wr_i);
  end
endmodule // flash_ram_model

// ---- tb/core_addr_tb.sv ----
/* Self-checking bench for core_addr with a flash model on its strobes.
   Assumes the design package is compiled first. */
`timescale 1ns/1ns
module core_addr_tb;
  import core_addr_pkg::*;
  logic sys_clk_i = 0, rst_i = 1, start_i = 0, carry_i = 0, acc_zero_i = 0;
  logic bit_val_i = 0, cmp_equal_i = 0, ind_sel_i = 0, code_read_i = 0;
  logic ext_write_i = 0, flash_write_en_i = 0, sfr_wr_i = 0, sfr_rd_i = 0;
  logic [7:0] opcode_i = 0, op1_i = 0, op2_i = 0, dec_src_i = 0;
  logic [7:0] program_status_word_i = 0, ind_ptr_i = 0, direct_addr_i = 0;
  logic [7:0] bit_addr_i = 0, sfr_addr_i = 0, sfr_wdata_i = 0;
  logic [15:0] pc_i = 0, ret_addr_i = 0;
  logic [2:0] reg_sel_i = 0;
  sp_op_t sp_op_i = SPOP_NONE;
  logic busy_o, done_o, branch_taken_o, clear_bit_o, ind_upper_o;
  logic direct_sfr_o, bit_in_sfr_o, sfr_bitable_o, code_rd_o, code_wr_o;
  logic xdata_wr_o, sfr_hit_o, rec_overflow_o, rec_underflow_o;
  logic [15:0] next_pc_o;
  logic [2:0] cycles_o, bit_pos_o;
  logic [7:0] reg_addr_o, ind_reg_addr_o, bit_byte_o, sfr_rdata_o;
  logic [7:0] push_addr_o, stack_top_pointer_o, b;
  logic [31:0] rec_o;
  logic ovf, unf;
  int compares = 0, miscompares = 0, cyc = 0, sp, fill, nrd = 0, nwr = 0;
  int nxw = 0, rd_cnt, wr_cnt, xw_cnt, seed = 32'hEFD7204C;
  logic [7:0] ops [18] = '{OP_JC, OP_JNC, OP_JZ, OP_JNZ, OP_SJMP, OP_JB,
    OP_JNB, OP_JBC, OP_LJMP, OP_DECREMENT_JUMP_NONZERO_D, OP_NOP, OP_SPARE, 8'hB5, 8'hD9, 8'hE1,
    OP_LCALL, OP_RET, 8'h31};
  core_addr dut (.*);
  flash_ram_model mem (.sys_clk_i, .code_rd_i(code_rd_o),
    .code_wr_i(code_wr_o), .xdata_wr_i(xdata_wr_o), .rd_cnt_o(rd_cnt),
    .wr_cnt_o(wr_cnt), .xw_cnt_o(xw_cnt));
  // Free-running 10 MHz clock.
  initial begin
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic step();
    @(posedge sys_clk_i);
    #1;
  endtask
  task automatic do_reset(int n);
    rst_i = 1;
    repeat (n) step();
    rst_i = 0;
    sp = 7; fill = 0; ovf = 0; unf = 0;
    check("sp_rst", stack_top_pointer_o, 8'h07);
    check("rec_rst", rec_o, 0);
    check("flags_rst", {rec_overflow_o, rec_underflow_o}, 0);
  endtask
  // Model one instruction, then run it and time it from the start edge.
  task automatic run(logic [7:0] op);
    int n, len, base, tk, cd, off;
    logic [15:0] nx, tg;
    opcode_i = op; op1_i = $random(seed); op2_i = $random(seed);
    pc_i = 16'({$random(seed)} % 64000); // below reserved code
    {carry_i, acc_zero_i, bit_val_i, cmp_equal_i} = 4'($random(seed));
    dec_src_i = 8'({$random(seed)} % 3);
    ret_addr_i = 16'($random(seed));
    len = 2; base = 2; cd = 1; tk = 1;
    case (op)
      OP_JC: tk = carry_i;
      OP_JNC: tk = !carry_i;
      OP_JZ: tk = acc_zero_i;
      OP_JNZ: tk = !acc_zero_i;
      OP_SJMP: begin base = 3; cd = 0; end
      OP_JB, OP_JBC: begin len = 3; tk = bit_val_i; end
      OP_JNB: begin len = 3; tk = !bit_val_i; end
      OP_DECREMENT_JUMP_NONZERO_D: begin len = 3; tk = dec_src_i != 1; end
      OP_LJMP, OP_LCALL: begin len = 3; base = 4; cd = 0; end
      OP_RET: begin len = 1; base = 5; cd = 0; end
      OP_NOP, OP_SPARE: begin len = 1; base = 1; cd = 0; tk = 0; end
      default: if (op[4:0] == OP_AJMP_LO || op[4:0] == OP_ACALL_LO) begin
          base = 3; cd = 0;
        end
        else if (op[7:4] == OP_COMPARE_JUMP_UNEQUAL_HI) begin len = 3; tk = !cmp_equal_i; end
        else tk = dec_src_i != 1;
    endcase
    if (len == 3 && cd) base = 3;
    off = (len == 3) ? $signed(op2_i) : $signed(op1_i);
    nx = pc_i + 16'(len);
    tg = nx + 16'(off);
    if (op == OP_LJMP || op == OP_LCALL) tg = {op1_i, op2_i};
    if (op == OP_RET) tg = ret_addr_i;
    if (cd == 0 && base == 3 && op != OP_SJMP) tg = {nx[15:11], op[7:5], op1_i};
    if (!tk) tg = nx;
    start_i = 1;
    step();
    start_i = 0;
    n = 1;
    while (done_o !== 1'b1 && n < 9) begin
      step();
      n++;
    end
    check("cycles", n, base + (cd & tk));
    check("cycles_o", cycles_o, base + (cd & tk));
    check("next_pc", next_pc_o, tg);
    check("clear_bit", clear_bit_o, op == OP_JBC && bit_val_i);
    check("taken", branch_taken_o, tk);
    check("busy", busy_o, 0);
    step();
  endtask
  // Apply one stack operation and follow pointer and record in the model.
  task automatic sop(sp_op_t o);
    sp_op_i = o;
    case (o)
      SPOP_PUSH, SPOP_INC: begin sp++; fill++; end
      SPOP_CALL: begin sp += 2; fill += 2; end
      SPOP_POP, SPOP_DEC: begin sp--; fill--; end
      SPOP_RET: begin sp -= 2; fill -= 2; end
      default: ;
    endcase
    if (fill > 32) begin ovf = 1; fill = 32; end
    if (fill < 0) begin unf = 1; fill = 0; end
    step();
    check("sp", stack_top_pointer_o, sp & 255);
    check("push_addr", push_addr_o, (sp + 1) & 255);
    check("ovf", rec_overflow_o, ovf);
    check("unf", rec_underflow_o, unf);
  endtask
  // The tests need well under a thousand cycles; a hang ends the run.
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    do_reset(8);
    repeat (4) foreach (ops[i]) run(ops[i]);
    repeat (10) sop(SPOP_PUSH);
    repeat (11) sop(SPOP_CALL);
    sop(SPOP_INC);
    sop(SPOP_NONE);
    do_reset(2);
    sop(SPOP_PUSH); sop(SPOP_POP); sop(SPOP_CALL); sop(SPOP_RET);
    sop(SPOP_DEC);
    repeat (40) sop(sp_op_t'({$random(seed)} % 7));
    // A register write wins over a push in the same cycle.
    sfr_wr_i = 1; sfr_addr_i = SP_ADDR; sfr_wdata_i = $random(seed);
    sp_op_i = SPOP_PUSH;
    step();
    sfr_wr_i = 0; sp_op_i = SPOP_NONE; sfr_rd_i = 1;
    check("sp_wr", stack_top_pointer_o, sfr_wdata_i);
    check("hit", sfr_hit_o, 1);
    step();
    check("sp_rd", sfr_rdata_o, sfr_wdata_i);
    sfr_addr_i = 8'h80; // unoccupied, reads as zero
    check("miss", sfr_hit_o, 0);
    step();
    check("miss_rd", sfr_rdata_o, 0);
    sfr_rd_i = 0;
    repeat (64) begin
      {program_status_word_i, direct_addr_i, bit_addr_i, ind_ptr_i} =
        $random(seed);
      {reg_sel_i, ind_sel_i, code_read_i, ext_write_i, flash_write_en_i} =
        7'($random(seed));
      nrd += code_read_i;
      nwr += ext_write_i & flash_write_en_i;
      nxw += ext_write_i & !flash_write_en_i;
      #1;
      b = bit_addr_i[7] ? bit_addr_i & 8'hF8 : BIT_BYTE_BASE + bit_addr_i[6:3];
      check("ind_reg", ind_reg_addr_o,
        {program_status_word_i[4:3], 2'h0, ind_sel_i});
      check("bit_byte", bit_byte_o, b);
      check("bit_pos", bit_pos_o, bit_addr_i[2:0]);
      check("bit_sfr", bit_in_sfr_o, bit_addr_i[7]);
      if (direct_addr_i[7])
        check("bitable", sfr_bitable_o, direct_addr_i[2:0] == 3'h0);
      else
        check("not_bitable", sfr_bitable_o, 0);
      check("xdata_wr", xdata_wr_o, ext_write_i & !flash_write_en_i);
      check("code_rd", code_rd_o, code_read_i);
      step();
    end
    code_read_i = 0; ext_write_i = 0;
    step();
    check("flash_rd", rd_cnt, nrd);
    check("flash_wr", wr_cnt, nwr);
    check("xdata_n", xw_cnt, nxw);
    end_sim();
  end
endmodule // core_addr_tb
